// file: protection_supervisor_xcap_discharge_bench.sv
/*
 * Bench for psx_supervisor: start-up, stage faults, latched and safe restart,
 * config failure, X-capacitor discharge, register port.
 * Assumes psx_cfg_model answers the config read handshake.
 */
module protection_supervisor_xcap_discharge_bench
    import psx_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int DW = 20;
    // healthy pins; mains rise comes from the pulser
    localparam psx_sense_s GOOD = 24'h65_5000;
    // brownout, boost low, boost cycle ends x2, resonant on-time, guard,
    // boost over, short, supply low
    localparam logic [23:0] FM[9] = '{24'h0C_0000, 24'h00_3000, 24'h00_0010,
        24'h00_0008, 24'h00_0004, 24'h00_0001, 24'h00_C000, 24'h03_0000, 24'hC0_0000};
    localparam logic [6:0] FD[9] = '{7'h10, 7'h20, 7'h38, 7'h38, 7'h34, 7'h34,
        7'h10, 7'h00, 7'h01};
    // ext temp, int temp, supply over, timeout, overpower, drain, coil
    localparam int LB[7] = '{9, 10, 8, 7, 6, 11, 5};
    localparam int LF[7] = '{F_OTE, F_OTI, F_SOVP, F_STO, F_OPP, F_DRN, F_COIL};
    logic clk = 1'b0, resetn = 1'b0, regWr = 1'b0, regRd = 1'b0;
    logic rdP1 = 1'b0, look = 1'b0, rise = 1'b0, mainsOn = 1'b1;
    logic [3:0] failCnt = 4'h0;
    logic [ADDR_W-1:0] regAddr = '0;
    logic [DATA_W-1:0] regWdata = '0, regRdata;
    psx_sense_s sense = GOOD;
    logic cfgReadReq, cfgReadDone, cfgReadValid, pfcEnable, llcEnable;
    logic pfcCycleOff, llcCycleOff, dischargeOn, supplyRecharge;
    logic [DATA_W-1:0] rdQ[$];
    logic [13:0] outQ[$];
    logic [13:0] note;
    int num_errors = 0, n_compared = 0;
    integer seed = 32'hef72;
    wire logic [6:0] outs = {cfgReadReq, pfcEnable, llcEnable, pfcCycleOff,
        llcCycleOff, dischargeOn, supplyRecharge};
    wire psx_sense_s senseW = sense | {3'h0, rise, 20'h0_0000};

    psx_supervisor #(.DCH_WAIT(DW)) dut_u (.clk(clk), .resetn(resetn),
        .senseIn(senseW), .cfgReadReq(cfgReadReq), .cfgReadDone(cfgReadDone),
        .cfgReadValid(cfgReadValid), .regAddr(regAddr), .regWdata(regWdata),
        .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .pfcEnable(pfcEnable),
        .llcEnable(llcEnable), .pfcCycleOff(pfcCycleOff), .llcCycleOff(llcCycleOff),
        .dischargeOn(dischargeOn), .supplyRecharge(supplyRecharge));
    psx_cfg_model model_u (.clk(clk), .resetn(resetn), .cfgReadReq(cfgReadReq),
        .cfgReadDone(cfgReadDone), .cfgReadValid(cfgReadValid), .failCnt(failCnt));

    initial begin
        forever #2 clk = ~clk;
    end
    // mains rises at random spacing, always below the discharge wait
    initial begin
        forever begin
            repeat (6 + ($unsigned($random(seed)) % 6)) @(posedge clk);
            rise <= mainsOn;
            repeat (3) @(posedge clk);
            rise <= 1'b0;
        end
    end

    task automatic cmp(input string nm, input logic [15:0] e, input logic [15:0] s);
        n_compared++;
        if (s !== e) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", nm, e, s);
        end
    endtask
    always @(posedge clk) begin
        if (rdP1) begin
            cmp("regRdata", rdQ.pop_front(), regRdata);
        end
        if (look) begin
            note = outQ.pop_front();
            cmp("outputs", {9'h0, note[6:0]}, {9'h0, outs & note[13:7]});
        end
        rdP1 <= regRd;
    end

    task automatic report_and_stop();
        if (num_errors == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge clk);
        regWr <= 1'b0;
    endtask
    task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
        @(posedge clk);
        rdQ.push_back(e);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clk);
        regRd <= 1'b0;
    endtask
    task automatic see(input int n, input logic [6:0] e, input logic [6:0] m = 7'h7f);
        repeat (n) @(posedge clk);
        outQ.push_back({m, e});
        look <= 1'b1;
        @(posedge clk);
        look <= 1'b0;
    endtask
    task automatic put(input psx_sense_s s);
        @(posedge clk);
        sense <= s;
    endtask
    task automatic start(input logic [3:0] f, input logic [6:0] e, input logic [6:0] m);
        @(posedge clk);
        resetn <= 1'b0;
        failCnt <= f;
        sense <= psx_sense_s'(GOOD ^ 24'h20_0000);
        repeat (5) @(posedge clk);
        resetn <= 1'b1;
        see(10, 7'h00, 7'h7e);
        sense <= GOOD;
        see(40, e, m);
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        report_and_stop();
    end
    initial begin
        start(4'h2, 7'h30, 7'h7f);
        rd(REG_CTRL, CTRL_RST);
        rd(REG_OCPN, OCPN_RST);
        rd(REG_PROT, 16'h0001 << F_CFG);
        wr(4'hF, 16'($random(seed)));
        rd(4'hF, 16'h0000);
        wr(REG_PROT, 16'($random(seed)));
        rd(REG_PROT, 16'h0001 << F_CFG);
        for (int i = 0; i < 9; i++) begin
            put(psx_sense_s'(GOOD ^ FM[i]));
            see(12, FD[i]);
            put(GOOD);
            see(40, 7'h30);
        end
        rd(REG_PROT, (16'h0001 << F_SCP) | (16'h0001 << F_BOVP) | (16'h0001 << F_LTON)
            | (16'h0001 << F_CMR) | (16'h0001 << F_CFG));
        mainsOn <= 1'b0;
        see(12, 7'h30);
        see(30, 7'h32);
        mainsOn <= 1'b1;
        see(20, 7'h30);
        for (int m = 0; m < 2; m++) begin
            for (int i = 0; i < 7; i++) begin
                start(4'h0, 7'h30, 7'h7f);
                wr(REG_CTRL, (m == 1) ? 16'h0009 : 16'h0000);
                rd(REG_CTRL, (m == 1) ? 16'h0009 : 16'h0000);
                // supply drops below start with the fault, so regulation shows
                put(psx_sense_s'(GOOD ^ (24'h40_0000 | (24'h00_0001 << LB[i]))));
                see(12, 7'h01);
                put(GOOD);
                see(40, (m == 1 && i < 6) ? 7'h00 : 7'h30);
                rd(REG_PROT, 16'h0001 << LF[i]);
            end
        end
        start(4'hF, 7'h00, 7'h7e);
        see(100, 7'h00, 7'h7e);
        rd(REG_PROT, 16'h0001 << F_CFG);
        report_and_stop();
    end
endmodule

// file: psx_cfg_model.sv
/*
 * Config memory model: answers each read request with a done pulse, failing
 * the first failCnt tries after a mains reset.
 * Assumes cfgReadReq is a registered level on the shared clock.
 */
module psx_cfg_model (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // read handshake
    input wire logic cfgReadReq,
    output logic cfgReadDone,
    output logic cfgReadValid,
    // bench control
    input wire logic [3:0] failCnt
);
    int tries = 0;
    wire logic ans = cfgReadReq && !cfgReadDone;
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            tries <= 0;
            cfgReadDone <= 1'b0;
            cfgReadValid <= 1'b0;
        end else begin
            cfgReadDone <= ans;
            // valid line toggles outside a done pulse; all ones never answers valid
            cfgReadValid <= ans ? ((failCnt != 4'hF) && (tries >= int'(failCnt))) : !cfgReadValid;
            tries <= ans ? tries + 1 : tries;
        end
    end
endmodule

// file: psx_pkg.sv
/*
 * Package for the protection supervisor with X-capacitor discharge: register
 * offsets, field positions, reset values, timing counts, fault identifiers.
 * Assumes a 250 MHz controller clock and digitised comparator inputs.
 */
// Notes on behaviour
// R01 - rising mains keeps discharge path disabled
// R02 - no rise for wait time: discharge
// R03 - rising mains again stops discharge
// R04 - supply undervoltage stops both, recharges supply
// R05 - restart once supply above start level
// R06 - latched or safe restart regulates supply
// R07 - read configuration at 12 V first
// R08 - read failure: protect, both off, mains reset
// R09 - validity checked once, read repeated
// R10 - temperature, overvoltage, timeout, overpower: configured stop
// R11 - short or fast disable: stop, log, restart
// R12 - brownout stops boost stage, resonant optional
// R13 - boost overvoltage stops boost, optional resonant
// R14 - boost on-time or overcurrent: cycle off
// R15 - coil short: both off, safe restart
// R16 - boost undervoltage stops resonant stage only
// R17 - resonant on-time: switch off, record
// R18 - capacitive guard recorded, no stop
// R19 - resonant overcurrent: early end, then stop
// R20 - drain overvoltage: stop, log, configured mode
// R21 - sticky flags cleared only by reset
// R22 - discharge timer restarts on each rise
// R23 - internal overtemp follows external selection
package psx_pkg;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 16;
    localparam logic [ADDR_W-1:0] REG_CTRL = 4'h0;
    localparam logic [ADDR_W-1:0] REG_PROT = 4'h1;
    localparam logic [ADDR_W-1:0] REG_STAT = 4'h2;
    localparam logic [ADDR_W-1:0] REG_DCHW = 4'h3;
    localparam logic [ADDR_W-1:0] REG_OCPN = 4'h4;
    // control register fields
    localparam int CTL_LATCH = 0;
    localparam int CTL_BO_LLC = 1;
    localparam int CTL_OVP_LLC = 2;
    localparam int CTL_DRN_LATCH = 3;
    localparam logic [DATA_W-1:0] CTRL_RST = 16'h0000;
    // protection register bits
    localparam int F_CFG = 0;
    localparam int F_OTI = 1;
    localparam int F_OTE = 2;
    localparam int F_SCP = 3;
    localparam int F_BOVP = 4;
    localparam int F_DRN = 5;
    localparam int F_COIL = 6;
    localparam int F_SOVP = 7;
    localparam int F_LTON = 8;
    localparam int F_CMR = 9;
    localparam int F_LOCP = 10;
    localparam int F_STO = 11;
    localparam int F_OPP = 12;
    localparam int NFLAG = 13;
    // discharge wait, microseconds, and its cycle count
    localparam int CLK_MHZ = 250;
    localparam int DCH_WAIT_US = 100;
    localparam int DCH_WAIT_CYC = DCH_WAIT_US * CLK_MHZ;
    localparam logic [DATA_W-1:0] OCPN_RST = 16'h0004;
    localparam int CFG_TRIES_W = 4;
    typedef enum {ST_OFF, ST_CFG, ST_RUN, ST_SAFE, ST_LATCH, ST_CFGFAIL} psx_state_e;
    typedef struct packed {
        logic supplyUv;
        logic supplyStart;
        logic supply12v;
        logic mainsRise;
        logic brownout;
        logic brownin;
        logic boostShort;
        logic boostScpStart;
        logic boostOvp;
        logic boostBelowReg;
        logic boostUv;
        logic boostAboveStart;
        logic drainOvp;
        logic otInt;
        logic otExt;
        logic supplyOvp;
        logic startupTimeout;
        logic overpower;
        logic coilShort;
        logic pfcMaxOn;
        logic pfcOcp;
        logic llcMaxOn;
        logic llcOcp;
        logic cmrActive;
    } psx_sense_s;
endpackage

// file: psx_supervisor.sv
/*
 * Protection supervisor: decides stage enables, recovery mode, fault log,
 * configuration read and X-capacitor discharge.
 * Assumes sense comparators arrive asynchronously as levels; config memory
 * handshake is on the same clock; resetn comes from mains detection.
 */
// Decided for this implementation: the register addresses and the address-and-strobe port.
module psx_supervisor
    import psx_pkg::*;
#(
    parameter int DCH_WAIT = DCH_WAIT_CYC
) (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // sense pins, asynchronous
    input wire psx_sense_s senseIn,
    // config memory
    output logic cfgReadReq,
    input wire logic cfgReadDone,
    input wire logic cfgReadValid,
    // register port
    input wire logic [ADDR_W-1:0] regAddr,
    input wire logic [DATA_W-1:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [DATA_W-1:0] regRdata,
    // stage controls
    output logic pfcEnable,
    output logic llcEnable,
    output logic pfcCycleOff,
    output logic llcCycleOff,
    output logic dischargeOn,
    output logic supplyRecharge
);
    localparam int SW = $bits(psx_sense_s);
    localparam int DW = $clog2(DCH_WAIT + 1);

    // three-stage synchroniser, change taken when stages 2 and 3 agree
    logic [SW-1:0] s1Q, s2Q, s3Q, sFiltQ;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s1Q <= '0;
            s2Q <= '0;
            s3Q <= '0;
            sFiltQ <= '0;
        end else begin
            s1Q <= senseIn;
            s2Q <= s1Q;
            s3Q <= s2Q;
            sFiltQ <= (s2Q & s3Q) | (sFiltQ & (s2Q | s3Q));
        end
    end
    psx_sense_s sn;
    assign sn = psx_sense_s'(sFiltQ);

    // registers
    logic [DATA_W-1:0] ctrlQ, ocpLimitQ;
    logic [NFLAG-1:0] protQ;
    wire latchSel = ctrlQ[CTL_LATCH];
    wire boStopLlc = ctrlQ[CTL_BO_LLC];
    wire ovpStopLlc = ctrlQ[CTL_OVP_LLC];
    wire drnLatch = ctrlQ[CTL_DRN_LATCH];

    psx_state_e stQ, stD;
    logic [CFG_TRIES_W-1:0] triesQ;
    logic cfgCheckedQ;
    logic [DATA_W-1:0] ocpRunQ;
    logic [DW-1:0] dchCntQ;
    logic dchQ;
    logic scpHoldQ, boHoldQ, ovpHoldQ, uvHoldQ;

    wire running = (stQ == ST_RUN);
    wire ocpTrip = running && sn.llcOcp && (ocpRunQ + 16'h0001 >= ocpLimitQ); // R19
    wire tempTrip = sn.otInt || sn.otExt;
    // R10 R23: internal overtemp shares the external selection
    wire cfgStop = running && (tempTrip || sn.supplyOvp || sn.startupTimeout
                   || sn.overpower || ocpTrip);
    wire drnStop = running && sn.drainOvp; // R20
    wire coilStop = running && sn.coilShort; // R15
    wire protect = (stQ == ST_SAFE) || (stQ == ST_LATCH) || (stQ == ST_CFGFAIL);

    // recovery state machine
    always_comb begin
        stD = stQ;
        case (stQ)
            ST_OFF: if (sn.supply12v && sn.supplyStart) begin
                stD = cfgCheckedQ ? ST_RUN : ST_CFG; // R07 R05
            end
            ST_CFG: if (cfgReadDone) begin
                if (cfgReadValid) stD = ST_RUN;
                else if (&triesQ) stD = ST_CFGFAIL; // R08
            end
            ST_RUN: begin
                if (sn.supplyUv) stD = ST_OFF; // R04
                else if (coilStop) stD = ST_SAFE;
                else if (drnStop) stD = drnLatch ? ST_LATCH : ST_SAFE;
                else if (cfgStop) stD = latchSel ? ST_LATCH : ST_SAFE;
            end
            ST_SAFE: if (!tempTrip && !sn.drainOvp && !sn.coilShort) stD = ST_OFF;
            ST_LATCH: stD = ST_LATCH;
            ST_CFGFAIL: stD = ST_CFGFAIL; // R08
            default: stD = ST_OFF;
        endcase
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            stQ <= ST_OFF;
            triesQ <= '0;
            cfgCheckedQ <= 1'b0;
        end else begin
            stQ <= stD;
            if (stQ == ST_CFG && cfgReadDone && !cfgReadValid) triesQ <= triesQ + 1'b1; // R09
            if (stQ == ST_CFG && cfgReadDone && cfgReadValid) cfgCheckedQ <= 1'b1; // R09
        end
    end

    // held stops with their own restart levels
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            scpHoldQ <= 1'b1;
            boHoldQ <= 1'b0;
            ovpHoldQ <= 1'b0;
            uvHoldQ <= 1'b1;
            ocpRunQ <= '0;
        end else begin
            if (sn.boostShort) scpHoldQ <= 1'b1; // R11
            else if (sn.boostScpStart) scpHoldQ <= 1'b0;
            if (sn.brownout) boHoldQ <= 1'b1; // R12
            else if (sn.brownin) boHoldQ <= 1'b0;
            if (sn.boostOvp) ovpHoldQ <= 1'b1; // R13
            else if (sn.boostBelowReg) ovpHoldQ <= 1'b0;
            if (sn.boostUv) uvHoldQ <= 1'b1; // R16
            else if (sn.boostAboveStart) uvHoldQ <= 1'b0;
            if (!running) ocpRunQ <= '0;
            else if (sn.llcOcp) ocpRunQ <= ocpRunQ + 16'h0001;
            else ocpRunQ <= '0;
        end
    end

    // sticky protection register; hardware set only
    logic [NFLAG-1:0] setV;
    always_comb begin
        setV = '0;
        setV[F_CFG] = (stQ == ST_CFG) && cfgReadDone && !cfgReadValid;
        setV[F_OTI] = running && sn.otInt;
        setV[F_OTE] = running && sn.otExt;
        setV[F_SCP] = sn.boostShort;
        setV[F_BOVP] = sn.boostOvp;
        setV[F_DRN] = drnStop;
        setV[F_COIL] = coilStop;
        setV[F_SOVP] = running && sn.supplyOvp;
        setV[F_LTON] = running && sn.llcMaxOn;
        setV[F_CMR] = running && sn.cmrActive;
        setV[F_LOCP] = ocpTrip;
        setV[F_STO] = running && sn.startupTimeout;
        setV[F_OPP] = running && sn.overpower;
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) protQ <= '0;
        else protQ <= protQ | setV; // R21 R11 R13 R17 R18
    end

    // X-capacitor discharge
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            dchCntQ <= '0;
            dchQ <= 1'b0;
        end else if (sn.mainsRise) begin
            dchCntQ <= '0; // R22
            dchQ <= 1'b0; // R01 R03
        end else if (dchCntQ >= DW'(DCH_WAIT - 1)) begin
            dchQ <= 1'b1; // R02
        end else begin
            dchCntQ <= dchCntQ + 1'b1;
        end
    end

    // register port
    wire wrCtrl = regWr && (regAddr == REG_CTRL);
    wire wrOcpn = regWr && (regAddr == REG_OCPN);
    logic [DATA_W-1:0] rdMux;
    always_comb begin
        case (regAddr)
            REG_CTRL: rdMux = ctrlQ;
            REG_PROT: rdMux = DATA_W'(protQ);
            REG_STAT: rdMux = {10'h000, dchQ, scpHoldQ, boHoldQ, ovpHoldQ, uvHoldQ, protect};
            REG_DCHW: rdMux = DATA_W'(dchCntQ);
            REG_OCPN: rdMux = ocpLimitQ;
            default: rdMux = 16'h0000;
        endcase
    end
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ctrlQ <= CTRL_RST;
            ocpLimitQ <= OCPN_RST;
            regRdata <= '0;
        end else begin
            if (wrCtrl) ctrlQ <= regWdata;
            if (wrOcpn) ocpLimitQ <= regWdata;
            regRdata <= regRd ? rdMux : 16'h0000;
        end
    end

    // outputs from flops
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pfcEnable <= 1'b0;
            llcEnable <= 1'b0;
            pfcCycleOff <= 1'b0;
            llcCycleOff <= 1'b0;
            dischargeOn <= 1'b0;
            supplyRecharge <= 1'b0;
            cfgReadReq <= 1'b0;
        end else begin
            pfcEnable <= (stD == ST_RUN) && !scpHoldQ && !boHoldQ && !ovpHoldQ; // R04 R11 R12 R13
            llcEnable <= (stD == ST_RUN) && !scpHoldQ && !uvHoldQ
                         && !(boHoldQ && boStopLlc) && !(ovpHoldQ && ovpStopLlc); // R16 R12 R13
            pfcCycleOff <= sn.pfcMaxOn || sn.pfcOcp; // R14
            llcCycleOff <= sn.llcMaxOn || sn.llcOcp || sn.cmrActive; // R17 R19 R18
            dischargeOn <= dchQ;
            // R04 R06
            supplyRecharge <= ((stQ == ST_OFF) || protect) && !sn.supplyStart;
            cfgReadReq <= (stD == ST_CFG);
        end
    end
    // checks
    property p_dch_clear;
        @(posedge clk) disable iff (!resetn) sn.mainsRise |=> !dchQ ##1 !dischargeOn;
    endproperty
    a_dch_clear: assert property (p_dch_clear) else $error("discharge not cleared"); // R03

    property p_uv_stop;
        @(posedge clk) disable iff (!resetn) (running && sn.supplyUv) |=> !pfcEnable && !llcEnable;
    endproperty
    a_uv_stop: assert property (p_uv_stop) else $error("stages on in undervoltage"); // R04

    property p_sticky;
        @(posedge clk) disable iff (!resetn) protQ[F_SCP] |=> protQ[F_SCP];
    endproperty
    a_sticky: assert property (p_sticky) else $error("protection flag lost"); // R21

    property p_latch_hold;
        @(posedge clk) disable iff (!resetn) (stQ == ST_LATCH) |=> (stQ == ST_LATCH) && !pfcEnable;
    endproperty
    a_latch_hold: assert property (p_latch_hold) else $error("latch left"); // R10

    property p_cfgfail;
        @(posedge clk) disable iff (!resetn) (stQ == ST_CFGFAIL) |=> !pfcEnable && !llcEnable;
    endproperty
    a_cfgfail: assert property (p_cfgfail) else $error("stages on after config fail"); // R08

    property p_coil;
        @(posedge clk) disable iff (!resetn) coilStop && !sn.supplyUv |=> (stQ == ST_SAFE);
    endproperty
    a_coil: assert property (p_coil) else $error("coil short not safe restart"); // R15

    property p_uvboost;
        @(posedge clk) disable iff (!resetn) uvHoldQ |=> !llcEnable;
    endproperty
    a_uvboost: assert property (p_uvboost) else $error("resonant on under boost uv"); // R16

    property p_cycle;
        @(posedge clk) disable iff (!resetn) sn.pfcOcp |=> pfcCycleOff;
    endproperty
    a_cycle: assert property (p_cycle) else $error("boost cycle not ended"); // R14

    property p_dch_set;
        @(posedge clk) disable iff (!resetn) (!sn.mainsRise && dchCntQ >= DW'(DCH_WAIT - 1)) |=> dchQ;
    endproperty
    a_dch_set: assert property (p_dch_set) else $error("discharge not started"); // R02

    property p_dch_restart;
        @(posedge clk) disable iff (!resetn) sn.mainsRise |=> (dchCntQ == '0);
    endproperty
    a_dch_restart: assert property (p_dch_restart) else $error("wait timer not restarted"); // R22

    property p_uv_recharge;
        @(posedge clk) disable iff (!resetn) (stQ == ST_OFF) && !sn.supplyStart |=> supplyRecharge;
    endproperty
    a_uv_recharge: assert property (p_uv_recharge) else $error("supply not recharged"); // R04

    property p_prot_recharge;
        @(posedge clk) disable iff (!resetn) protect && !sn.supplyStart |=> supplyRecharge;
    endproperty
    a_prot_recharge: assert property (p_prot_recharge) else $error("supply not regulated"); // R06

    property p_run_no_recharge;
        @(posedge clk) disable iff (!resetn) running |=> !supplyRecharge;
    endproperty
    a_run_no_recharge: assert property (p_run_no_recharge) else $error("recharge while running"); // R06

    property p_uv_off;
        @(posedge clk) disable iff (!resetn) running && sn.supplyUv |=> (stQ == ST_OFF);
    endproperty
    a_uv_off: assert property (p_uv_off) else $error("undervoltage not stopped"); // R04

    property p_restart;
        @(posedge clk) disable iff (!resetn)
            (stQ == ST_OFF) && sn.supply12v && sn.supplyStart && cfgCheckedQ |=> running;
    endproperty
    a_restart: assert property (p_restart) else $error("no restart at start level"); // R05

    property p_cfg_first;
        @(posedge clk) disable iff (!resetn) (stQ == ST_OFF) && sn.supply12v && sn.supplyStart
            && !cfgCheckedQ |=> (stQ == ST_CFG) && cfgReadReq;
    endproperty
    a_cfg_first: assert property (p_cfg_first) else $error("config not read first"); // R07

    property p_cfg_quiet;
        @(posedge clk) disable iff (!resetn) (stQ == ST_CFG) |-> !pfcEnable && !llcEnable;
    endproperty
    a_cfg_quiet: assert property (p_cfg_quiet) else $error("switching during config read"); // R07

    property p_cfg_retry;
        @(posedge clk) disable iff (!resetn) (stQ == ST_CFG) && cfgReadDone && !cfgReadValid
            && !(&triesQ) |=> (stQ == ST_CFG);
    endproperty
    a_cfg_retry: assert property (p_cfg_retry) else $error("config read not repeated"); // R09

    property p_cfg_fail;
        @(posedge clk) disable iff (!resetn) (stQ == ST_CFG) && cfgReadDone && !cfgReadValid
            && (&triesQ) |=> (stQ == ST_CFGFAIL);
    endproperty
    a_cfg_fail: assert property (p_cfg_fail) else $error("config failure not taken"); // R08

    property p_cfg_flag;
        @(posedge clk) disable iff (!resetn)
            (stQ == ST_CFG) && cfgReadDone && !cfgReadValid |=> protQ[F_CFG];
    endproperty
    a_cfg_flag: assert property (p_cfg_flag) else $error("config failure not logged"); // R08

    property p_cfgfail_hold;
        @(posedge clk) disable iff (!resetn) (stQ == ST_CFGFAIL) |=> (stQ == ST_CFGFAIL);
    endproperty
    a_cfgfail_hold: assert property (p_cfgfail_hold) else $error("config failure left"); // R08

    property p_cfg_once;
        @(posedge clk) disable iff (!resetn) cfgCheckedQ |-> (stQ != ST_CFG);
    endproperty
    a_cfg_once: assert property (p_cfg_once) else $error("config read twice"); // R09

    property p_temp_stop;
        @(posedge clk) disable iff (!resetn) running && !sn.supplyUv && !sn.coilShort
            && !sn.drainOvp && tempTrip |=> protect && ((stQ == ST_LATCH) == $past(latchSel));
    endproperty
    a_temp_stop: assert property (p_temp_stop) else $error("temperature stop mode wrong"); // R10 R23

    property p_drn_stop;
        @(posedge clk) disable iff (!resetn) running && !sn.supplyUv && !sn.coilShort
            && sn.drainOvp |=> protect && ((stQ == ST_LATCH) == $past(drnLatch));
    endproperty
    a_drn_stop: assert property (p_drn_stop) else $error("drain stop mode wrong"); // R20

    property p_scp_off;
        @(posedge clk) disable iff (!resetn) scpHoldQ |=> !pfcEnable && !llcEnable;
    endproperty
    a_scp_off: assert property (p_scp_off) else $error("stages on during short"); // R11

    property p_bo_pfc;
        @(posedge clk) disable iff (!resetn) boHoldQ |=> !pfcEnable;
    endproperty
    a_bo_pfc: assert property (p_bo_pfc) else $error("boost on in brownout"); // R12

    property p_ovp_release;
        @(posedge clk) disable iff (!resetn)
            ovpHoldQ && !sn.boostOvp && sn.boostBelowReg |=> !ovpHoldQ;
    endproperty
    a_ovp_release: assert property (p_ovp_release) else $error("boost overvoltage stuck"); // R13

    property p_llc_maxon;
        @(posedge clk) disable iff (!resetn) running && sn.llcMaxOn |=> protQ[F_LTON] && llcCycleOff;
    endproperty
    a_llc_maxon: assert property (p_llc_maxon) else $error("resonant on-time not handled"); // R17

    property p_ocp_trip;
        @(posedge clk) disable iff (!resetn) ocpTrip && !sn.supplyUv && !coilStop && !drnStop
            |=> protect && protQ[F_LOCP];
    endproperty
    a_ocp_trip: assert property (p_ocp_trip) else $error("resonant overcurrent not stopped"); // R19

    property p_llc_cycle;
        @(posedge clk) disable iff (!resetn) sn.llcOcp |=> llcCycleOff;
    endproperty
    a_llc_cycle: assert property (p_llc_cycle) else $error("resonant cycle not ended"); // R19

    property p_coil_flag;
        @(posedge clk) disable iff (!resetn) coilStop |=> protQ[F_COIL];
    endproperty
    a_coil_flag: assert property (p_coil_flag) else $error("coil short not logged"); // R15

    property p_sticky_all;
        @(posedge clk) disable iff (!resetn) (protQ != '0) |=> ((protQ & $past(protQ)) == $past(protQ));
    endproperty
    a_sticky_all: assert property (p_sticky_all) else $error("protection flags lost"); // R21
endmodule
